/* lsi_pkg.sv */
// shared constants for the linked status interrupt logic
package lsi_pkg;
    localparam int FLAG_W = 32;
    // bank b bit positions
    localparam int BIT_TOTAL_IDLE = 0;
    localparam int BIT_FUND_IDLE = 1;
    localparam int BIT_APP_IDLE = 2;
    localparam int BIT_RESET_DONE = 15;
    localparam int BIT_SAG = 16;
    localparam int BIT_EXCESS_I = 17;
    localparam int BIT_EXCESS_V = 18;
    localparam int BIT_PEAK_I = 23;
    localparam int BIT_PEAK_V = 24;
    // bank a bit positions
    localparam int BIT_ACT_REV_LO = 6;
    localparam int BIT_REACT_REV_LO = 10;
    localparam int BIT_SUM_REV_0 = 9;
    localparam int BIT_SUM_REV_1 = 13;
    localparam int BIT_SUM_REV_2 = 18;
    // device register map (byte addresses of own choosing)
    localparam logic [7:0] ADDR_FLAGS_A = 8'h00;
    localparam logic [7:0] ADDR_FLAGS_B = 8'h04;
    localparam logic [7:0] ADDR_ENABLE_A = 8'h08;
    localparam logic [7:0] ADDR_ENABLE_B = 8'h0c;
    localparam logic [7:0] ADDR_PHASE_IDLE = 8'h10;
    localparam logic [7:0] ADDR_PHASE_EVENT = 8'h14;
    localparam logic [7:0] ADDR_PEAK_I = 8'h18;
    localparam logic [7:0] ADDR_PEAK_V = 8'h1c;
    localparam logic [7:0] ADDR_POLARITY = 8'h20;
    // host apb register map
    localparam logic [7:0] HADDR_CTRL = 8'h00;
    localparam logic [7:0] HADDR_STATUS = 8'h04;
    localparam logic [7:0] HADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] HADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] HADDR_FLAGS_A = 8'h10;
    localparam logic [7:0] HADDR_FLAGS_B = 8'h14;
    localparam logic [7:0] HADDR_LINKED = 8'h18;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam int SYNC_STAGES = 3;
endpackage

/* lsi_link_if.sv */
// register access and request lines between host and metering device
`timescale 1ns/1ps
interface lsi_link_if;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;
    logic interrupt_out_n_a;
    logic interrupt_out_n_b;
    modport dev (input req, input wr, input addr, input wdata,
                 output ack, output rdata, output interrupt_out_n_a, output interrupt_out_n_b);
    modport host (output req, output wr, output addr, output wdata,
                  input ack, input rdata, input interrupt_out_n_a, input interrupt_out_n_b);
endinterface

/* lsi_sync.sv */
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module lsi_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic din,
    output logic dout
);
    logic [2:0] sh_q;
    logic dout_q;
    // first stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= 3'h7;
            dout_q <= 1'b1;
        end else begin
            sh_q <= {sh_q[1:0], din};
            if (sh_q[1] == sh_q[2]) begin
                dout_q <= sh_q[2];
            end
        end
    end
    assign dout = dout_q;
endmodule

/* lsi_device.sv */
// device end: event flags, enable banks, linked phase registers, request lines
`timescale 1ns/1ps
module lsi_device (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link
    lsi_link_if.dev link,
    // event inputs, one-cycle pulses
    input wire logic [31:0] event_a,
    input wire logic [31:0] event_b,
    // phase indications captured alongside the events
    input wire logic [8:0] phase_idle_in,
    input wire logic [8:0] phase_event_in,
    input wire logic [2:0] peak_i_phase_in,
    input wire logic [2:0] peak_v_phase_in,
    input wire logic [11:0] polarity_in
);
    logic [31:0] flags_a_q, flags_b_q, enable_a_q, enable_b_q;
    logic [8:0] phase_idle_reg_q, phase_event_reg_q;
    logic [2:0] current_peak_phase_reg_q, voltage_peak_phase_reg_q;
    logic [11:0] phase_polarity_reg_q;
    logic done_q;
    logic ack_q;
    logic [31:0] rdata_q;
    wire wr_go = link.req && link.wr && !ack_q;
    wire rd_go = link.req && !link.wr && !ack_q;
    wire [31:0] clr_a = (wr_go && link.addr == lsi_pkg::ADDR_FLAGS_A) ? link.wdata : 32'h0;
    wire [31:0] clr_b = (wr_go && link.addr == lsi_pkg::ADDR_FLAGS_B) ? link.wdata : 32'h0;
    // reset-finished event raised once after reset release
    wire [31:0] done_ev = done_q ? 32'h0 : (32'h1 << lsi_pkg::BIT_RESET_DONE);
    wire [31:0] set_b = event_b | done_ev;
    // linked capture strobes
    wire idle_hit = event_b[lsi_pkg::BIT_TOTAL_IDLE] | event_b[lsi_pkg::BIT_FUND_IDLE]
                    | event_b[lsi_pkg::BIT_APP_IDLE];
    wire pev_hit = event_b[lsi_pkg::BIT_SAG] | event_b[lsi_pkg::BIT_EXCESS_I]
                   | event_b[lsi_pkg::BIT_EXCESS_V];
    wire pol_hit = (|event_a[lsi_pkg::BIT_ACT_REV_LO +: 3])
                   | (|event_a[lsi_pkg::BIT_REACT_REV_LO +: 3])
                   | event_a[lsi_pkg::BIT_SUM_REV_0] | event_a[lsi_pkg::BIT_SUM_REV_1]
                   | event_a[lsi_pkg::BIT_SUM_REV_2];
    // flags: set beats clear, set regardless of enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_a_q <= lsi_pkg::RESET_ZERO;
            flags_b_q <= lsi_pkg::RESET_ZERO;
            done_q <= 1'b0;
        end else begin
            flags_a_q <= (flags_a_q & ~clr_a) | event_a;
            flags_b_q <= (flags_b_q & ~clr_b) | set_b;
            done_q <= 1'b1;
        end
    end
    // linked phase registers updated with their flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_idle_reg_q <= 9'h0;
            phase_event_reg_q <= 9'h0;
            current_peak_phase_reg_q <= 3'h0;
            voltage_peak_phase_reg_q <= 3'h0;
            phase_polarity_reg_q <= 12'h0;
        end else begin
            if (idle_hit) phase_idle_reg_q <= phase_idle_in;
            if (pev_hit) phase_event_reg_q <= phase_event_in;
            if (event_b[lsi_pkg::BIT_PEAK_I]) current_peak_phase_reg_q <= peak_i_phase_in;
            if (event_b[lsi_pkg::BIT_PEAK_V]) voltage_peak_phase_reg_q <= peak_v_phase_in;
            if (pol_hit) phase_polarity_reg_q <= polarity_in;
        end
    end
    // enable banks and read mux; each access answered one cycle later
    wire [31:0] rd_mux =
        (link.addr == lsi_pkg::ADDR_FLAGS_A) ? flags_a_q :
        (link.addr == lsi_pkg::ADDR_FLAGS_B) ? flags_b_q :
        (link.addr == lsi_pkg::ADDR_ENABLE_A) ? enable_a_q :
        (link.addr == lsi_pkg::ADDR_ENABLE_B) ? enable_b_q :
        (link.addr == lsi_pkg::ADDR_PHASE_IDLE) ? {23'h0, phase_idle_reg_q} :
        (link.addr == lsi_pkg::ADDR_PHASE_EVENT) ? {23'h0, phase_event_reg_q} :
        (link.addr == lsi_pkg::ADDR_PEAK_I) ? {29'h0, current_peak_phase_reg_q} :
        (link.addr == lsi_pkg::ADDR_PEAK_V) ? {29'h0, voltage_peak_phase_reg_q} :
        (link.addr == lsi_pkg::ADDR_POLARITY) ? {20'h0, phase_polarity_reg_q} : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_a_q <= lsi_pkg::RESET_ZERO;
            enable_b_q <= lsi_pkg::RESET_ZERO;
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= link.req && !ack_q;
            if (rd_go) rdata_q <= rd_mux;
            if (wr_go && link.addr == lsi_pkg::ADDR_ENABLE_A) enable_a_q <= link.wdata;
            if (wr_go && link.addr == lsi_pkg::ADDR_ENABLE_B) enable_b_q <= link.wdata;
        end
    end
    // reset-finished cannot be masked, so force its enable
    wire [31:0] eff_b = enable_b_q | (32'h1 << lsi_pkg::BIT_RESET_DONE);
    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    // low while any enabled flag is set
    assign link.interrupt_out_n_a = ~|(flags_a_q & enable_a_q);
    assign link.interrupt_out_n_b = ~|(flags_b_q & eff_b);
endmodule

/* lsi_host.sv */
// host end: apb-driven service engine for the device request lines
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module lsi_host (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt to software
    output logic irq,
    // link
    lsi_link_if.host link
);
    typedef enum logic [2:0] {
        LSI_IDLE = 3'b000,
        LSI_RD_FLAGS = 3'b001,
        LSI_RD_LINK = 3'b010,
        LSI_WR_BACK = 3'b011,
        LSI_DONE = 3'b100,
        LSI_CFG = 3'b101
    } lsi_state_e;
    lsi_state_e st_q, st_d;
    logic line_q; // bank being serviced: 0 = a, 1 = b
    logic ena_q;
    logic [1:0] pend_q; // edge latches per line
    logic [1:0] prev_q;
    logic [31:0] fa_q, fb_q, linked_q, flags_q;
    logic [1:0] stat_q, mask_q;
    logic req_q;
    logic [7:0] addr_q;
    logic wr_q;
    logic [31:0] wdata_q;
    logic [31:0] prdata_q;
    logic na_s, nb_s;
    logic cfg_q; // enable write waiting for the link
    logic cfg_b_q; // 0 = bank a, 1 = bank b
    logic [31:0] cfg_data_q;
    // pins cross from the device domain
    lsi_sync u_sync_a (.pclk(pclk), .presetn(presetn), .din(link.interrupt_out_n_a), .dout(na_s));
    lsi_sync u_sync_b (.pclk(pclk), .presetn(presetn), .din(link.interrupt_out_n_b), .dout(nb_s));
    wire [1:0] fall = prev_q & ~{nb_s, na_s};
    // apb decode
    wire apb_wr = psel && penable && pwrite;
    wire apb_rd = psel && penable && !pwrite;
    wire hit_ctrl = paddr == lsi_pkg::HADDR_CTRL;
    wire hit_stat = paddr == lsi_pkg::HADDR_IRQ_STAT;
    wire hit_mask = paddr == lsi_pkg::HADDR_IRQ_MASK;
    wire hit_fa = paddr == lsi_pkg::HADDR_FLAGS_A;
    wire hit_fb = paddr == lsi_pkg::HADDR_FLAGS_B;
    wire mapped = hit_ctrl || hit_stat || hit_mask || paddr == lsi_pkg::HADDR_STATUS
                  || paddr == lsi_pkg::HADDR_FLAGS_A || paddr == lsi_pkg::HADDR_FLAGS_B
                  || paddr == lsi_pkg::HADDR_LINKED;
    wire busy = st_q != LSI_IDLE;
    wire [31:0] rd_mux =
        hit_ctrl ? {31'h0, ena_q} :
        (paddr == lsi_pkg::HADDR_STATUS) ? {27'h0, pend_q, line_q, busy, ~nb_s & ~na_s} :
        hit_stat ? {30'h0, stat_q} :
        hit_mask ? {30'h0, mask_q} :
        (paddr == lsi_pkg::HADDR_FLAGS_A) ? fa_q :
        (paddr == lsi_pkg::HADDR_FLAGS_B) ? fb_q :
        (paddr == lsi_pkg::HADDR_LINKED) ? linked_q : 32'h0;
    // linked register address chosen from the bits that were set
    function automatic logic [7:0] link_addr(input logic bank, input logic [31:0] f);
        if (!bank) begin
            // only the reversal bits own a polarity record; 14..17 do not
            link_addr = (|f[13:6] || f[lsi_pkg::BIT_SUM_REV_2]) ? lsi_pkg::ADDR_POLARITY
                        : 8'hff;
        end else if (|f[2:0]) begin
            link_addr = lsi_pkg::ADDR_PHASE_IDLE;
        end else if (|f[18:16]) begin
            link_addr = lsi_pkg::ADDR_PHASE_EVENT;
        end else if (f[lsi_pkg::BIT_PEAK_I]) begin
            link_addr = lsi_pkg::ADDR_PEAK_I;
        end else if (f[lsi_pkg::BIT_PEAK_V]) begin
            link_addr = lsi_pkg::ADDR_PEAK_V;
        end else begin
            link_addr = 8'hff;
        end
    endfunction
    wire [7:0] laddr = link_addr(line_q, link.rdata);
    wire pick_b = pend_q[1];
    // service sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            // enable writes go first so a new setting governs the next service
            LSI_IDLE: if (cfg_q) st_d = LSI_CFG;
                      else if (ena_q && |pend_q) st_d = LSI_RD_FLAGS;
            LSI_RD_FLAGS: if (link.ack) st_d = (laddr != 8'hff) ? LSI_RD_LINK : LSI_WR_BACK;
            LSI_RD_LINK: if (link.ack) st_d = LSI_WR_BACK;
            LSI_WR_BACK: if (link.ack) st_d = LSI_DONE;
            LSI_DONE: st_d = LSI_IDLE;
            LSI_CFG: if (link.ack) st_d = LSI_IDLE;
            default: st_d = LSI_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= LSI_IDLE;
            line_q <= 1'b0;
            req_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 8'h0;
            wdata_q <= 32'h0;
            flags_q <= 32'h0;
            linked_q <= 32'h0;
            fa_q <= 32'h0;
            fb_q <= 32'h0;
        end else begin
            st_q <= st_d;
            req_q <= 1'b0;
            if (st_q == LSI_IDLE && st_d == LSI_CFG) begin
                addr_q <= cfg_b_q ? lsi_pkg::ADDR_ENABLE_B : lsi_pkg::ADDR_ENABLE_A;
                wr_q <= 1'b1;
                wdata_q <= cfg_data_q;
                req_q <= 1'b1;
            end else if (st_q == LSI_IDLE && st_d == LSI_RD_FLAGS) begin
                line_q <= pick_b;
                addr_q <= pick_b ? lsi_pkg::ADDR_FLAGS_B : lsi_pkg::ADDR_FLAGS_A;
                wr_q <= 1'b0;
                req_q <= 1'b1;
            end else if (link.ack && st_q == LSI_RD_FLAGS) begin
                flags_q <= link.rdata;
                if (line_q) fb_q <= link.rdata;
                else fa_q <= link.rdata;
                addr_q <= (laddr != 8'hff) ? laddr : addr_q;
                wr_q <= laddr == 8'hff;
                wdata_q <= link.rdata;
            end else if (link.ack && st_q == LSI_RD_LINK) begin
                linked_q <= link.rdata;
                wr_q <= 1'b1;
                addr_q <= line_q ? lsi_pkg::ADDR_FLAGS_B : lsi_pkg::ADDR_FLAGS_A;
            end else if (!link.ack) begin
                // raised again two cycles after each read answer, so the device sees a one-cycle gap
                req_q <= req_q || (busy && st_q != LSI_DONE);
            end
        end
    end
    // edge latches: set wins over service clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 2'h3;
            pend_q <= 2'h0;
            stat_q <= 2'h0;
        end else begin
            prev_q <= {nb_s, na_s};
            for (int i = 0; i < 2; i++) begin
                if (st_q == LSI_IDLE && st_d == LSI_RD_FLAGS && pick_b == i[0]) begin
                    pend_q[i] <= fall[i];
                end else begin
                    pend_q[i] <= pend_q[i] | fall[i];
                end
                if (st_q == LSI_WR_BACK && link.ack && line_q == i[0]) begin
                    stat_q[i] <= 1'b1;
                end else if (apb_rd && hit_stat && prdata_q[i]) begin
                    // only bits already captured for the reader are cleared
                    stat_q[i] <= 1'b0;
                end
            end
        end
    end
    // apb registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ena_q <= 1'b0;
            mask_q <= 2'h0;
            prdata_q <= 32'h0;
        end else begin
            if (apb_wr && hit_ctrl) ena_q <= pwdata[0];
            if (apb_wr && hit_mask) mask_q <= pwdata[1:0];
            if (psel && !penable) prdata_q <= rd_mux;
        end
    end
    // writes to the last-flags addresses load a device enable bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 1'b0;
            cfg_b_q <= 1'b0;
            cfg_data_q <= 32'h0;
        end else begin
            if (apb_wr && (hit_fa || hit_fb)) begin
                cfg_q <= 1'b1; // a fresh write wins and is sent after a service; during an enable write it is kept only if it lands on its ack
                cfg_b_q <= hit_fb;
                cfg_data_q <= pwdata;
            end else if (st_q == LSI_CFG && link.ack) begin
                cfg_q <= 1'b0;
            end
        end
    end
    assign prdata = prdata_q;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign irq = |(stat_q & mask_q);
    assign link.req = req_q;
    assign link.wr = wr_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
endmodule

/* lsi_link_monitor.sv */
// concurrent checks on the link between host end and device end
`timescale 1ns/1ps
module lsi_link_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link signals
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic ack,
    input wire logic [31:0] rdata,
    input wire logic interrupt_out_n_a,
    input wire logic interrupt_out_n_b
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded transfers; linked masks cover idle, event, peak and polarity groups
    wire is_fa = addr == lsi_pkg::ADDR_FLAGS_A;
    wire is_fb = addr == lsi_pkg::ADDR_FLAGS_B;
    wire fl_rd = ack && !wr && (is_fa || is_fb);
    wire fl_wr = req && !ack && wr && (is_fa || is_fb);
    wire ln_rd = ack && !wr && addr >= lsi_pkg::ADDR_PHASE_IDLE;
    wire ln_hit = is_fb ? |(rdata & 32'h0187_0007) : |(rdata & 32'h0004_3fc0);
    logic [31:0] last_q;
    logic pend_q;
    logic [2:0] cnt_q;
    // last flags read, linked read still owed, edges since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 32'h0;
            pend_q <= 1'b0;
            cnt_q <= 3'h0;
        end else begin
            if (fl_rd) last_q <= rdata;
            pend_q <= fl_rd ? ln_hit : (ln_rd ? 1'b0 : pend_q);
            if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
        end
    end
    property p_take; req && !ack |=> ack && req && $stable({wr, addr, wdata}); endproperty
    a_take: assert property (p_take) else $error("link request not answered");
    property p_pulse; ack |=> !ack; endproperty
    a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
    property p_drop; ack |=> !req; endproperty
    a_drop: assert property (p_drop) else $error("request held after ack");
    property p_same; fl_wr |-> wdata == last_q; endproperty
    a_same: assert property (p_same) else $error("flag write-back differs from read");
    property p_link; fl_wr |-> !pend_q; endproperty
    a_link: assert property (p_link) else $error("flags cleared before linked read");
    property p_rst; cnt_q == 3'h3 |-> !interrupt_out_n_b; endproperty
    a_rst: assert property (p_rst) else $error("no request after reset");
    property p_clear; fl_wr && is_fb && wdata[15] |-> ##[1:3] interrupt_out_n_b; endproperty
    a_clear: assert property (p_clear) else $error("request not released");
    property p_hold;
        $rose(interrupt_out_n_b) |-> $past(fl_wr, 1) || $past(fl_wr, 2) || $past(fl_wr, 3);
    endproperty
    a_hold: assert property (p_hold) else $error("request released without clear");
    // main scenarios reached
    c_clear: cover property (fl_wr && is_fb);
    c_link: cover property (ln_rd);
    c_fall: cover property ($fell(interrupt_out_n_b));
    c_cfg: cover property (req && wr && addr == lsi_pkg::ADDR_ENABLE_A);
endmodule

/* linked_status_interrupt_logic_tb.sv */
// self-checking bench for host end and device end joined by the link
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module linked_status_interrupt_logic_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, event_a = 32'h0, event_b = 32'h0;
    logic [8:0] idle_in = 9'h0, pev_in = 9'h0;
    logic [2:0] pki_in = 3'h0, pkv_in = 3'h0;
    logic [11:0] pol_in = 12'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [31:0] seed = 32'h8cc8;
    int miscompares = 0, n_checks = 0;
    lsi_link_if link();
    always #5 pclk = ~pclk;
    // both ends facing each other, checker beside the link
    lsi_device lsi_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
        .event_a(event_a), .event_b(event_b), .phase_idle_in(idle_in),
        .phase_event_in(pev_in), .peak_i_phase_in(pki_in), .peak_v_phase_in(pkv_in),
        .polarity_in(pol_in));
    lsi_host lsi_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    lsi_link_monitor lsi_link_monitor_inst (.pclk(pclk), .presetn(presetn), .req(link.req),
        .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata), .interrupt_out_n_a(link.interrupt_out_n_a),
        .interrupt_out_n_b(link.interrupt_out_n_b));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // linked value the host should fetch: idle, then event, then peak i, then peak v
    function automatic logic [31:0] exp_link(input logic [31:0] f, input logic [31:0] p);
        if (|f[2:0]) return {23'h0, p[8:0]};
        if (|f[18:16]) return {23'h0, p[17:9]};
        if (f[23]) return {29'h0, p[20:18]};
        if (f[24]) return {29'h0, p[23:21]};
        return 32'h0;
    endfunction
    // apb master; an idle edge after release avoids double drive on back-to-back calls
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin miscompares++; close_out(); end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // each pass resets both ends, so reset is also exercised in mid-run
    initial begin
        logic [31:0] r, eb, ph, stat, eva, ea, xv;
        logic e;
        int n;
        logic [31:0] corner [4] = '{32'h0, 32'h7, 32'h0100_0000, 32'h0083_0000};
        for (int i = 0; i < 8; i++) begin
            presetn <= 1'b0;
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            eb = (i < 4) ? corner[i] : xs();
            ph = xs();
            eva = xs();
            event_a <= eva;
            event_b <= eb;
            idle_in <= ph[8:0];
            pev_in <= ph[17:9];
            pki_in <= ph[20:18];
            pkv_in <= ph[23:21];
            pol_in <= ph[31:20];
            @(posedge pclk);
            event_a <= 32'h0;
            event_b <= 32'h0;
            apb(1'b0, lsi_pkg::HADDR_CTRL, 32'h0, r, e);
            `CHK(r, 32'h0)
            `CHK(link.interrupt_out_n_b, 1'b0)
            apb(1'b1, lsi_pkg::HADDR_IRQ_MASK, {30'h0, i[0], 1'b0}, r, e);
            `CHK(link.interrupt_out_n_b, 1'b0)
            apb(1'b1, lsi_pkg::HADDR_CTRL, 32'h1, r, e);
            n = 0;
            stat = 32'h0;
            while (stat[1] !== 1'b1 && n < 60) begin
                if (i[0]) begin
                    @(posedge pclk);
                    stat[1] = irq;
                end else begin
                    apb(1'b0, lsi_pkg::HADDR_IRQ_STAT, 32'h0, stat, e);
                end
                n++;
            end
            if (n >= 60) begin miscompares++; close_out(); end
            if (i[0]) begin
                apb(1'b0, lsi_pkg::HADDR_IRQ_STAT, 32'h0, r, e);
                `CHK(r, 32'h2)
            end
            `CHK(irq, 1'b0)
            apb(1'b0, lsi_pkg::HADDR_FLAGS_B, 32'h0, r, e);
            `CHK(r, eb | 32'h0000_8000)
            apb(1'b0, lsi_pkg::HADDR_FLAGS_A, 32'h0, r, e);
            `CHK(r, 32'h0)
            apb(1'b0, lsi_pkg::HADDR_LINKED, 32'h0, r, e);
            `CHK(r, exp_link(eb, ph))
            `CHK(link.interrupt_out_n_b, 1'b1)
            `CHK(link.interrupt_out_n_a, 1'b1)
            apb(1'b0, 8'h40, 32'h0, r, e);
            `CHK({e, r}, 33'h1_0000_0000)
            // open bank a enables: request follows flag and enable, then is serviced
            ea = (i == 0) ? 32'h0 : xs();
            apb(1'b1, lsi_pkg::HADDR_FLAGS_A, ea, r, e);
            repeat (3) @(posedge pclk);
            `CHK(link.interrupt_out_n_a, ~|(eva & ea))
            repeat (30) @(posedge pclk);
            `CHK(link.interrupt_out_n_a, 1'b1)
            apb(1'b0, lsi_pkg::HADDR_FLAGS_A, 32'h0, r, e);
            `CHK(r, (|(eva & ea)) ? eva : 32'h0)
            xv = (|(eva & ea) && |(eva & 32'h0004_3fc0)) ? {20'h0, ph[31:20]}
                 : exp_link(eb, ph);
            apb(1'b0, lsi_pkg::HADDR_LINKED, 32'h0, r, e);
            `CHK(r, xv)
        end
        close_out();
    end
endmodule
